//--- pkg/acs_consts.svh
`ifndef ACS_CONSTS_SVH
`define ACS_CONSTS_SVH
// =====================================================
// Timing figures and code limits
// =====================================================
`define ACS_CLK_HZ 100000000
`define ACS_CONV_60_MS 133
`define ACS_CONV_50_MS 160
`define ACS_CONV_60_CYC ((`ACS_CONV_60_MS * 64'd100000000) / 64'd1000)
`define ACS_CONV_50_CYC ((`ACS_CONV_50_MS * 64'd100000000) / 64'd1000)
`define ACS_EXT_CONV_PERIODS 20510
`define ACS_DOUT_SCK_MAX 32
`define ACS_DOUT_INT_US 1670
`define ACS_DOUT_INT_CYC ((`ACS_DOUT_INT_US * 64'd100000000) / 64'd1000000)
`define ACS_DOUT_EXT_PERIODS 256
`define ACS_EXT_MIN_HZ 2560
`define ACS_EXT_GAP_CYC (64'd100000000 / `ACS_EXT_MIN_HZ)
`define ACS_CODE_HI 24'h11ffff
`define ACS_CODE_LO 24'hf00000
`define ACS_CHAN_RST 4'h0
`endif

//--- pkg/acs_pkg.sv
`default_nettype none
// =====================================================
// Types of the conversion sequencer
// =====================================================
package acs_pkg;
  typedef enum logic [1:0] {ACS_SLEEP, ACS_CONVERT, ACS_DOUT} acs_state_t;
  // Channel word: enable then three-bit code
  typedef struct packed {
    logic en;
    logic [2:0] code;
  } acs_chan_t;
endpackage : acs_pkg
`default_nettype wire

//--- design/acs_sequencer.sv
`include "acs_consts.svh"
`default_nettype none
module acs_sequencer #(
  parameter int unsigned NUM_CHAN = 8,
  parameter longint unsigned CONV_60_CYC = `ACS_CONV_60_CYC,
  parameter longint unsigned CONV_50_CYC = `ACS_CONV_50_CYC,
  parameter longint unsigned DOUT_INT_CYC = `ACS_DOUT_INT_CYC,
  parameter longint unsigned EXT_GAP_CYC = `ACS_EXT_GAP_CYC
) (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // Serial side
  input wire logic converter_select_n_i,
  input wire logic sck_i,
  input wire logic int_sck_mode_i,
  input wire logic mux_select_n_i,
  input wire logic mux_clk_i,
  input wire logic mux_din_i,
  input wire logic rate_select_clock_in_i,
  // Raw result from modulator, signed 24 bit scaled
  input wire logic [23:0] raw_result_i,
  // Status and outputs
  output logic [1:0] state_o,
  output logic [7:0] mux_analog_out_o,
  output logic ext_clk_mode_o,
  output logic notch_50_o,
  output logic [23:0] result_o,
  output logic eoc_n_o
);
  // =====================================================
  // Elaboration check
  // =====================================================
  if (NUM_CHAN != 4 && NUM_CHAN != 8) begin : g_chk
    $error("NUM_CHAN must be 4 or 8");
  end
  // Counters are 32 bits wide, so longer spans cannot be served
  if (CONV_60_CYC > 64'h00000000ffffffff || CONV_50_CYC > 64'h00000000ffffffff ||
      DOUT_INT_CYC > 64'h00000000ffffffff || EXT_GAP_CYC > 64'h00000000ffffffff) begin : g_wide
    $error("cycle counts must fit the 32-bit counters");
  end

  acs_pkg::acs_state_t state_r, state_nxt;
  acs_pkg::acs_chan_t shift_r, shift_nxt, chan_r, chan_nxt, conv_chan_r, conv_chan_nxt;
  logic [31:0] cnt_r, cnt_nxt;
  logic [31:0] gap_r, gap_nxt;
  logic [5:0] sck_cnt_r, sck_cnt_nxt;
  logic sck_q_r, mclk_q_r, msel_q_r, rs_q_r, cs_q_r;
  logic ext_r, ext_nxt, n50_r, n50_nxt;
  logic [23:0] res_r, res_nxt;
  logic [7:0] mux_r, mux_nxt;
  logic sck_rise, mclk_rise, msel_fall, rs_edge, rs_rise, cs_rise;
  logic [31:0] conv_len;
  logic eoc_n_r, eoc_n_nxt;
  logic prime_r; // Low until the edge samplers hold a real pin level

  // =====================================================
  // Edge detection, inputs taken as synchronous
  // =====================================================
  // Gated by prime_r: a pin parked high through reset must not look like an edge
  assign sck_rise = prime_r & sck_i & ~sck_q_r;
  assign mclk_rise = prime_r & mux_clk_i & ~mclk_q_r;
  assign msel_fall = prime_r & ~mux_select_n_i & msel_q_r;
  assign rs_edge = prime_r & (rate_select_clock_in_i ^ rs_q_r);
  assign rs_rise = prime_r & rate_select_clock_in_i & ~rs_q_r;
  assign cs_rise = prime_r & converter_select_n_i & ~cs_q_r;
  // Notch followed live; a change mid-conversion spoils only that conversion
  assign conv_len = n50_r ? 32'(CONV_50_CYC) : 32'(CONV_60_CYC);

  // Clock source and notch detection
  always_comb begin
    gap_nxt = gap_r;
    ext_nxt = ext_r;
    n50_nxt = n50_r;
    if (rs_edge) begin
      gap_nxt = '0;
      ext_nxt = 1'b1;
    end else if (gap_r >= 32'(EXT_GAP_CYC)) begin
      ext_nxt = 1'b0;
      n50_nxt = rate_select_clock_in_i;
    end else begin
      gap_nxt = gap_r + 32'h1;
    end
  end

  // Mux shifter: select high shifts, fall applies
  always_comb begin
    shift_nxt = shift_r;
    chan_nxt = chan_r;
    if (mux_select_n_i && mclk_rise) begin
      shift_nxt = {shift_r[2:0], mux_din_i};
    end
    if (msel_fall && shift_r.en) begin
      chan_nxt = shift_r;
    end
    mux_nxt = '0;
    if (chan_r.en && (32'(chan_r.code) < NUM_CHAN)) begin
      mux_nxt[chan_r.code] = 1'b1;
    end
  end

  // Conversion state machine
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sck_cnt_nxt = sck_cnt_r;
    conv_chan_nxt = conv_chan_r;
    res_nxt = res_r;
    case (state_r)
      acs_pkg::ACS_CONVERT: begin
        // External clock counts its own periods; internal counts system cycles
        if (!ext_r || rs_rise) begin
          cnt_nxt = cnt_r + 32'h1;
        end
        if ((ext_r && cnt_r >= 32'(`ACS_EXT_CONV_PERIODS)) ||
            (!ext_r && cnt_r >= conv_len)) begin
          state_nxt = acs_pkg::ACS_SLEEP;
          if ($signed(raw_result_i) > $signed(`ACS_CODE_HI)) begin
            res_nxt = `ACS_CODE_HI;
          end else if ($signed(raw_result_i) < $signed(`ACS_CODE_LO)) begin
            res_nxt = `ACS_CODE_LO;
          end else begin
            res_nxt = raw_result_i;
          end
        end
      end
      acs_pkg::ACS_SLEEP: begin
        // Result held; the mux shifter is not gated by state, so programming works in every state
        if (!converter_select_n_i && sck_rise) begin
          state_nxt = acs_pkg::ACS_DOUT;
          sck_cnt_nxt = 6'h1;
          cnt_nxt = '0;
        end
      end
      acs_pkg::ACS_DOUT: begin
        if (sck_rise) begin
          sck_cnt_nxt = sck_cnt_r + 6'h1;
        end
        if (int_sck_mode_i && (!ext_r || rs_rise)) begin
          cnt_nxt = cnt_r + 32'h1;
        end
        if (cs_rise || sck_cnt_r >= 6'(`ACS_DOUT_SCK_MAX) ||
            (int_sck_mode_i && !ext_r && cnt_r >= 32'(DOUT_INT_CYC)) ||
            (int_sck_mode_i && ext_r && cnt_r >= 32'(`ACS_DOUT_EXT_PERIODS))) begin
          state_nxt = acs_pkg::ACS_CONVERT;
          conv_chan_nxt = chan_r;
          cnt_nxt = '0;
        end
      end
      default: state_nxt = acs_pkg::ACS_CONVERT;
    endcase
    // Busy flag registered so the output comes straight from a flip-flop
    eoc_n_nxt = (state_nxt == acs_pkg::ACS_CONVERT);
  end

  // Registers, frozen while clock enable is low
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_r <= acs_pkg::ACS_CONVERT;
      cnt_r <= '0;
      gap_r <= '0;
      sck_cnt_r <= '0;
      shift_r <= `ACS_CHAN_RST;
      chan_r <= `ACS_CHAN_RST;
      conv_chan_r <= `ACS_CHAN_RST;
      mux_r <= '0;
      res_r <= '0;
      ext_r <= 1'b0;
      n50_r <= 1'b0;
      sck_q_r <= 1'b0;
      mclk_q_r <= 1'b0;
      msel_q_r <= 1'b0;
      rs_q_r <= 1'b0;
      cs_q_r <= 1'b1;
      eoc_n_r <= 1'b1;
      prime_r <= 1'b0;
    end else if (clk_en_i) begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      gap_r <= gap_nxt;
      sck_cnt_r <= sck_cnt_nxt;
      shift_r <= shift_nxt;
      chan_r <= chan_nxt;
      conv_chan_r <= conv_chan_nxt;
      mux_r <= mux_nxt;
      res_r <= res_nxt;
      ext_r <= ext_nxt;
      n50_r <= n50_nxt;
      sck_q_r <= sck_i;
      mclk_q_r <= mux_clk_i;
      msel_q_r <= mux_select_n_i;
      rs_q_r <= rate_select_clock_in_i;
      cs_q_r <= converter_select_n_i;
      eoc_n_r <= eoc_n_nxt;
      prime_r <= 1'b1;
    end
  end

  // Outputs straight from flip-flops
  assign state_o = state_r;
  assign mux_analog_out_o = mux_r;
  assign ext_clk_mode_o = ext_r;
  assign notch_50_o = n50_r;
  assign result_o = res_r;
  assign eoc_n_o = eoc_n_r;

  // =====================================================
  // Assertions
  // =====================================================
  a_clamp_high: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $signed(res_r) <= $signed(`ACS_CODE_HI)) else $error("result above clamp");
  a_clamp_low: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $signed(res_r) >= $signed(`ACS_CODE_LO)) else $error("result below clamp");
  a_mux_shift: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && mux_select_n_i && mclk_rise |=> shift_r[0] == $past(mux_din_i))
    else $error("mux bit not shifted");
  a_mux_apply: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && msel_fall && shift_r.en |=> chan_r == $past(shift_r))
    else $error("channel not applied");
  a_mux_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && !msel_fall |=> chan_r == $past(chan_r))
    else $error("channel changed without select fall");
  a_all_off: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && !chan_r.en |=> mux_r == 8'h00) else $error("channel on while off");
  a_sleep_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && state_r == acs_pkg::ACS_SLEEP && !sck_rise |=>
    state_r == acs_pkg::ACS_SLEEP) else $error("left sleep early");
  a_result_held: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_r == acs_pkg::ACS_SLEEP |=> $stable(res_r)) else $error("result changed");
  a_new_chan: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && state_r == acs_pkg::ACS_DOUT && state_nxt == acs_pkg::ACS_CONVERT |=>
    conv_chan_r == $past(chan_r)) else $error("conversion channel stale");
  a_dout_limit: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    sck_cnt_r <= 6'(`ACS_DOUT_SCK_MAX) + 6'h1) else $error("data output too long");
  c_conv_done: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_r == acs_pkg::ACS_CONVERT ##1 state_r == acs_pkg::ACS_SLEEP);
  c_dout: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    state_r == acs_pkg::ACS_DOUT);
  c_ext: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i) ext_r);
  c_dout_abort: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clk_en_i && state_r == acs_pkg::ACS_DOUT && cs_rise);
endmodule : acs_sequencer
`default_nettype wire

//--- tb/acs_host_model.sv
`default_nettype none
// =====================================================
// Host side of the serial port
// =====================================================
module acs_host_model (
  // Clock
  input wire logic sys_clk_i,
  // Serial lines toward the sequencer
  output logic adc_cs_n_o,
  output logic sck_o,
  output logic mux_sel_n_o,
  output logic mux_clk_o,
  output logic mux_din_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle levels; SCK stands still outside frames, the shift clock moves outside them only in stray_mux_clk
  initial begin
    adc_cs_n_o = 1'b1;
    sck_o = 1'b0;
    mux_sel_n_o = 1'b0;
    mux_clk_o = 1'b0;
    mux_din_o = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask : tick
  // Converter select has one driver: this model
  task automatic set_cs(input logic v);
    adc_cs_n_o <= v;
  endtask : set_cs
  // Each level held two edges so the edge sampler cannot miss it
  task automatic pulse_sck(input int n);
    repeat (n) begin
      sck_o <= 1'b1;
      tick(2);
      sck_o <= 1'b0;
      tick(2);
    end
  endtask : pulse_sck
  // Enable bit first, then the code MSB first
  task automatic shift_word(input acs_pkg::acs_chan_t w);
    mux_sel_n_o <= 1'b1;
    for (int i = 3; i >= 0; i--) begin
      mux_din_o <= w[i];
      tick(2);
      mux_clk_o <= 1'b1;
      tick(2);
      mux_clk_o <= 1'b0;
      tick(1);
    end
    mux_sel_n_o <= 1'b0;
    mux_din_o <= ~w[0]; // Released line shows no stale bit
    tick(1);
  endtask : shift_word
  // Shift clock wiggled while the select is low
  task automatic stray_mux_clk();
    mux_din_o <= 1'b1;
    repeat (4) begin
      mux_clk_o <= 1'b1;
      tick(2);
      mux_clk_o <= 1'b0;
      tick(2);
    end
  endtask : stray_mux_clk
endmodule : acs_host_model
`default_nettype wire

//--- tb/acs_sequencer_tb.sv
`include "acs_consts.svh"
`default_nettype none
// =====================================================
// Self-checking bench of the sequencer
// =====================================================
module acs_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // Shortened counts keep the run small
  localparam int C60 = 200;
  localparam int C50 = 240;
  localparam int DINT = 50;
  localparam int GAP = 20;
  logic sys_clk_i = 1'b0;
  logic reset_n_i, clk_en_i, int_sck_mode_i, rate_r;
  logic [23:0] raw_r;
  logic [15:0] lfsr_r = 16'd24493;
  logic cs_n, sck, msel_n, mclk, mdin;
  logic [1:0] state_o;
  logic [7:0] mux_o;
  logic ext_o, notch_o, eoc_n_o;
  logic [23:0] result_o;
  int error_cnt = 0;
  int num_checks = 0;
  int cyc;
  acs_host_model host_inst (.sys_clk_i(sys_clk_i), .adc_cs_n_o(cs_n), .sck_o(sck),
    .mux_sel_n_o(msel_n), .mux_clk_o(mclk), .mux_din_o(mdin));
  acs_sequencer #(.CONV_60_CYC(C60), .CONV_50_CYC(C50), .DOUT_INT_CYC(DINT),
    .EXT_GAP_CYC(GAP)) acs_sequencer_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .clk_en_i(clk_en_i), .converter_select_n_i(cs_n), .sck_i(sck),
    .int_sck_mode_i(int_sck_mode_i), .mux_select_n_i(msel_n), .mux_clk_i(mclk),
    .mux_din_i(mdin), .rate_select_clock_in_i(rate_r), .raw_result_i(raw_r),
    .state_o(state_o), .mux_analog_out_o(mux_o), .ext_clk_mode_o(ext_o),
    .notch_50_o(notch_o), .result_o(result_o), .eoc_n_o(eoc_n_o));
  initial begin
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  // =====================================================
  // Helpers
  // =====================================================
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // Saturation seen in the raw result scale
  function automatic logic [23:0] clamp_exp(input logic [23:0] r);
    if ($signed(r) > $signed(`ACS_CODE_HI)) return `ACS_CODE_HI;
    if ($signed(r) < $signed(`ACS_CODE_LO)) return `ACS_CODE_LO;
    return r;
  endfunction : clamp_exp
  task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Bounded wait; a miss shows up as a state mismatch
  task automatic wait_st(input logic [1:0] s, input int lim);
    cyc = 0;
    while (state_o !== s && cyc < lim) begin
      @(posedge sys_clk_i);
      #1;
      cyc++;
    end
    check("state", {22'h0, state_o}, {22'h0, s});
  endtask : wait_st
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : close_out
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
  // =====================================================
  // Main sequence
  // =====================================================
  initial begin
    reset_n_i <= 1'b0;
    clk_en_i <= 1'b1;
    int_sck_mode_i <= 1'b0;
    rate_r <= 1'b0;
    raw_r <= 24'h3fffff;
    repeat (5) @(posedge sys_clk_i);
    reset_n_i <= 1'b1;
    @(posedge sys_clk_i);
    #1;
    check("reset state", {22'h0, state_o}, 24'h1);
    check("eoc busy", {23'h0, eoc_n_o}, 24'h1);
    wait_st(2'd0, C60 + 20);
    check("conv 60 time", {23'h0, cyc >= C60 - 4 && cyc <= C60 + 4}, 24'h1);
    check("clamp high", result_o, 24'h11ffff);
    check("notch 60", {23'h0, notch_o}, 24'h0);
    check("eoc done", {23'h0, eoc_n_o}, 24'h0);
    $display("test reset and first conversion done");
    // Programming only while asleep after a finished conversion
    for (int k = 0; k < 8; k++) begin
      host_inst.shift_word({1'b1, 3'(k)});
      host_inst.tick(3);
      #1;
      check("channel", {16'h0, mux_o}, 24'h1 << k);
      check("sleep kept", {22'h0, state_o}, 24'h0);
    end
    lfsr_r = lfsr_next(lfsr_r);
    host_inst.shift_word({1'b0, lfsr_r[2:0]});
    host_inst.tick(3);
    #1;
    check("disabled word", {16'h0, mux_o}, 24'h80);
    host_inst.stray_mux_clk();
    #1;
    check("stray clock", {16'h0, mux_o}, 24'h80);
    $display("test channel selection done");
    raw_r <= 24'hc00000;
    rate_r <= 1'b1;
    host_inst.set_cs(1'b0);
    host_inst.pulse_sck(1);
    #1;
    check("dout entry", {22'h0, state_o}, 24'h2);
    host_inst.pulse_sck(30);
    #1;
    check("dout held", {22'h0, state_o}, 24'h2);
    host_inst.pulse_sck(1);
    #1;
    check("dout 32 ends", {22'h0, state_o}, 24'h1);
    host_inst.set_cs(1'b1);
    wait_st(2'd0, C50 + 20);
    check("conv 50 time", {23'h0, cyc >= C50 - 8 && cyc <= C50 + 4}, 24'h1);
    check("notch 50", {23'h0, notch_o}, 24'h1);
    check("clamp low", result_o, 24'hf00000);
    $display("test full read and 50 Hz done");
    // Random results; two reads aborted by select, two cut by the internal limit
    for (int t = 0; t < 4; t++) begin
      lfsr_r = lfsr_next(lfsr_r);
      raw_r <= {lfsr_r[15], lfsr_r[15], lfsr_r[15], lfsr_r[12:0], lfsr_r[7:0]};
      int_sck_mode_i <= t[0];
      host_inst.set_cs(1'b0);
      host_inst.pulse_sck(1);
      if (t[0]) begin
        wait_st(2'd1, DINT + 10);
      end else begin
        host_inst.set_cs(1'b1);
        wait_st(2'd1, 6);
      end
      host_inst.set_cs(1'b1);
      wait_st(2'd0, C50 + 20);
      check("random result", result_o, clamp_exp(raw_r));
    end
    $display("test random results done");
    repeat (30) begin
      rate_r <= ~rate_r;
      host_inst.tick(3);
    end
    #1;
    check("ext clock", {23'h0, ext_o}, 24'h1);
    host_inst.tick(GAP + 8);
    #1;
    check("int clock", {23'h0, ext_o}, 24'h0);
    $display("test clock source done");
    // Clock enable low: a read request in sleep must leave no trace
    clk_en_i <= 1'b0;
    host_inst.set_cs(1'b0);
    host_inst.pulse_sck(2);
    #1;
    check("frozen sleep", {22'h0, state_o}, 24'h0);
    clk_en_i <= 1'b1;
    host_inst.set_cs(1'b1);
    host_inst.tick(2);
    #1;
    check("thawed sleep", {22'h0, state_o}, 24'h0);
    $display("test clock enable done");
    close_out();
  end
endmodule : acs_sequencer_tb
`default_nettype wire
